// File: tgl_consts.svh
/*
 Named offsets, field positions, operation codes and limits for the time, Gray and logic-contact datapath.
 Assumes inclusion by the datapath and its bench; definitions only.
*/
`ifndef TGL_CONSTS_SVH
`define TGL_CONSTS_SVH

// Byte offsets on the register bus
`define TGL_A_CTRL 7'h00
`define TGL_A_OPA 7'h04
`define TGL_A_OPB 7'h08
`define TGL_A_TIME 7'h0c
`define TGL_A_TIME_END 7'h20
`define TGL_A_RES 7'h24
`define TGL_A_RES_END 7'h3c
`define TGL_A_FLAGS 7'h40
`define TGL_A_ERRC 7'h44
`define TGL_A_CAL 7'h48
`define TGL_A_CAL_END 7'h60

// Control word layout
`define TGL_CTRL_WIDE 8

// Operation codes
`define TGL_OP_TSUB 8'h01
`define TGL_OP_CALRD 8'h02
`define TGL_OP_B2G 8'h03
`define TGL_OP_G2B 8'h04
`define TGL_OP_LD_AND 8'hd7
`define TGL_OP_LD_OR 8'hd8
`define TGL_OP_LD_XOR 8'hd9
`define TGL_OP_SE_AND 8'hda
`define TGL_OP_SE_OR 8'hdb
`define TGL_OP_SE_XOR 8'hdc
`define TGL_OP_CB_AND 8'hdd
`define TGL_OP_CB_OR 8'hde
`define TGL_OP_CB_XOR 8'hdf

// Flag register bit positions
`define TGL_F_BORROW 0
`define TGL_F_ZERO 1
`define TGL_F_ERR_A 2
`define TGL_F_ERR_B 3
`define TGL_F_GRAY 4
`define TGL_F_CONTACT 5

// Time and calendar limits
`define TGL_ERR_TIME 16'h0e1a
`define TGL_HOUR_MAX 16'h0017
`define TGL_MIN_MAX 16'h003b
`define TGL_HOURS_DAY 16'h0018
`define TGL_MIN_HOUR 16'h003c
`define TGL_YEAR_MAX 16'h0063
`define TGL_WDAY_MAX 16'h0007
`define TGL_MONTH_MAX 16'h000c
`define TGL_DAY_MAX 16'h001f
`define TGL_FIELD_MIN 16'h0001
`define TGL_SEC_HOUR 18'h00e10
`define TGL_SEC_MIN 18'h0003c
`define TGL_SEC_DAY 18'h15180

// Bus answers
`define TGL_RESP_OKAY 2'h0
`define TGL_RESP_SLVERR 2'h2

`endif

// File: tgl_pkg.sv
/*
 Types shared by the time, Gray and logic-contact datapath.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tgl_pkg;
   typedef logic [15:0] tgl_word_t;
   typedef enum logic [1:0] {TGL_FN_AND, TGL_FN_OR, TGL_FN_XOR} tgl_fn_e;
   typedef enum logic [1:0] {TGL_FORM_NONE, TGL_FORM_LOAD, TGL_FORM_SERIES, TGL_FORM_COMBINE} tgl_form_e;
endpackage

// File: tgl_exec_top.sv
/*
 Execution datapath for time subtraction, calendar read, Gray conversion and logic contacts, with AXI4-Lite slave.
 Assumes one 250 MHz clock, synchronous active-low reset, and calendar inputs synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "tgl_consts.svh"

// Operation
// [RL1] Time subtract writes hours, minutes, seconds
// [RL2] Bad time field: skip, both errors, 0E1A
// [RL3] Negative difference: borrow, add 24 hours
// [RL4] Zero result sets zero flag
// [RL5] Seven calendar fields, each within range
// [RL6] Calendar read copies seven fields in order
// [RL7] Year holds two digits, 00 to 99
// [RL8] Weekday Monday 1 through Sunday 7
// [RL9] Binary converts to reflected Gray code
// [RL10] Gray code converts back to binary
// [RL11] Gray sources range checked, else error
// [RL12] Contact active when combination nonzero
// [RL13] Operator picks AND, OR or XOR
// [RL14] Load codes 215-217 start new line
// [RL15] Series codes 218-220 AND with line
// [RL16] Combining codes 221-223 merge in series
// [RL17] Each contact in 16- and 32-bit forms
// [RL18] Hours 0-23, minutes and seconds 0-59
// [RL19] Fields are plain binary 16-bit words
module tgl_exec_top
   import tgl_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [6:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [6:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] cal_in [0:6],
   output logic contact_out,
   output logic operating_error_flag_a,
   output logic operating_error_flag_b
);

   logic aw_got, w_got, do_wr, do_exec;
   logic [6:0] aw_q;
   logic [31:0] w_q;
   logic [3:0] ws_q;
   logic [7:0] op, exec_op;
   logic wide, exec_wide;
   logic [31:0] opa, opb;
   tgl_word_t tm [0:5];
   tgl_word_t res [0:6];
   tgl_word_t cal [0:6];
   tgl_word_t error_code_reg;
   logic borrow_flag, zero_flag, gray_err;
   logic t_ok, g_ok, hit;
   logic [16:0] s_raw, m_raw, h_raw;
   tgl_word_t s_fix, m_fix, h_fix;
   logic [31:0] g_src, g_enc, g_dec, cmp_val;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp, next_bresp;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
         begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] idx(input logic [6:0] a, input logic [6:0] base);
      logic [6:0] rel;
      rel = a - base;
      return rel[4:2];
   endfunction

   function automatic logic [31:0] gray_to_binary(input logic [31:0] g);
      logic [31:0] b;
      b[31] = g[31];
      for (int i = 30; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   function automatic logic cal_ok(input int k, input tgl_word_t v);
      logic ok;
      case (k)
         0: ok = v <= `TGL_YEAR_MAX;
         1: ok = v >= `TGL_FIELD_MIN && v <= `TGL_WDAY_MAX;
         2: ok = v >= `TGL_FIELD_MIN && v <= `TGL_MONTH_MAX;
         3: ok = v >= `TGL_FIELD_MIN && v <= `TGL_DAY_MAX;
         4: ok = v <= `TGL_HOUR_MAX;
         default: ok = v <= `TGL_MIN_MAX;
      endcase
      return ok;
   endfunction

   function automatic tgl_form_e form_of(input logic [7:0] c);
      tgl_form_e f;
      case (c)
         `TGL_OP_LD_AND, `TGL_OP_LD_OR, `TGL_OP_LD_XOR: f = TGL_FORM_LOAD;
         `TGL_OP_SE_AND, `TGL_OP_SE_OR, `TGL_OP_SE_XOR: f = TGL_FORM_SERIES;
         `TGL_OP_CB_AND, `TGL_OP_CB_OR, `TGL_OP_CB_XOR: f = TGL_FORM_COMBINE;
         default: f = TGL_FORM_NONE;
      endcase
      return f;
   endfunction

   function automatic tgl_fn_e fn_of(input logic [7:0] c);
      tgl_fn_e f;
      case (c)
         `TGL_OP_LD_AND, `TGL_OP_SE_AND, `TGL_OP_CB_AND: f = TGL_FN_AND;
         `TGL_OP_LD_OR, `TGL_OP_SE_OR, `TGL_OP_CB_OR: f = TGL_FN_OR;
         default: f = TGL_FN_XOR;
      endcase
      return f;
   endfunction

   // Write path: address and data taken in either order, one write in flight
   assign do_wr = aw_got && w_got && !s_axi_bvalid;
   assign do_exec = do_wr && aw_q == `TGL_A_CTRL;
   assign exec_op = w_q[7:0];
   assign exec_wide = w_q[`TGL_CTRL_WIDE];

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_q <= 7'h00;
         w_q <= 32'h0;
         ws_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TGL_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= s_axi_awaddr;
            aw_got <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
            w_got <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= next_bresp;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_comb
   begin
      next_bresp = `TGL_RESP_OKAY;
      if (aw_q > `TGL_A_CAL_END || aw_q[1:0] != 2'h0)
      begin
         next_bresp = `TGL_RESP_SLVERR;
      end
   end

   // Operand registers; results, calendar copies and error code are read-only
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         op <= 8'h00;
         wide <= 1'b0;
         opa <= 32'h0;
         opb <= 32'h0;
         for (int k = 0; k < 6; k++)
         begin
            tm[k] <= 16'h0;
         end
      end
      else if (do_wr)
      begin
         if (aw_q == `TGL_A_CTRL)
         begin
            op <= exec_op;
            wide <= exec_wide;
         end
         else if (aw_q == `TGL_A_OPA)
         begin
            opa <= merge(opa, w_q, ws_q);
         end
         else if (aw_q == `TGL_A_OPB)
         begin
            opb <= merge(opb, w_q, ws_q);
         end
         else if (aw_q >= `TGL_A_TIME && aw_q <= `TGL_A_TIME_END && aw_q[1:0] == 2'h0)
         begin
            tm[idx(aw_q, `TGL_A_TIME)] <= 16'(merge({16'h0, tm[idx(aw_q, `TGL_A_TIME)]}, w_q, ws_q));
         end
      end
   end

   // Borrow chain from seconds up; hours wrap by one day
   assign t_ok = tm[0] <= `TGL_HOUR_MAX && tm[1] <= `TGL_MIN_MAX && tm[2] <= `TGL_MIN_MAX
      && tm[3] <= `TGL_HOUR_MAX && tm[4] <= `TGL_MIN_MAX && tm[5] <= `TGL_MIN_MAX; // [RL18]
   assign s_raw = {1'b0, tm[2]} - {1'b0, tm[5]};
   assign m_raw = {1'b0, tm[1]} - {1'b0, tm[4]} - {16'h0, s_raw[16]};
   assign h_raw = {1'b0, tm[0]} - {1'b0, tm[3]} - {16'h0, m_raw[16]};
   assign s_fix = s_raw[16] ? s_raw[15:0] + `TGL_MIN_HOUR : s_raw[15:0];
   assign m_fix = m_raw[16] ? m_raw[15:0] + `TGL_MIN_HOUR : m_raw[15:0];
   assign h_fix = h_raw[16] ? h_raw[15:0] + `TGL_HOURS_DAY : h_raw[15:0]; // [RL3]

   // Sign bit set means out of range for the chosen width
   assign g_src = exec_wide ? opa : {16'h0, opa[15:0]};
   assign g_ok = exec_wide ? !opa[31] : !opa[15]; // [RL11]
   assign g_enc = g_src ^ (g_src >> 1); // [RL9]
   assign g_dec = gray_to_binary(g_src); // [RL10]

   always_comb
   begin
      case (fn_of(exec_op)) // [RL13]
         TGL_FN_AND: cmp_val = opa & opb;
         TGL_FN_OR: cmp_val = opa | opb;
         default: cmp_val = opa ^ opb;
      endcase
      if (!exec_wide)
      begin
         cmp_val[31:16] = 16'h0; // [RL17]
      end
      hit = |cmp_val; // [RL12]
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < 7; k++)
         begin
            res[k] <= 16'h0;
         end
      end
      else if (do_exec)
      begin
         case (exec_op)
            `TGL_OP_TSUB:
            begin
               if (t_ok) // [RL2]
               begin
                  res[0] <= h_fix; // [RL1]
                  res[1] <= m_fix;
                  res[2] <= s_fix;
               end
            end
            `TGL_OP_CALRD:
            begin
               for (int k = 0; k < 7; k++)
               begin
                  res[k] <= cal[k]; // [RL6]
               end
            end
            `TGL_OP_B2G, `TGL_OP_G2B:
            begin
               if (g_ok)
               begin
                  res[0] <= exec_op == `TGL_OP_B2G ? g_enc[15:0] : g_dec[15:0];
                  if (exec_wide)
                  begin
                     res[1] <= exec_op == `TGL_OP_B2G ? g_enc[31:16] : g_dec[31:16];
                  end
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // Flags in bits 0 to 4 clear by writing ones; the contact bit does not; a set in the same cycle wins
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         borrow_flag <= 1'b0;
         zero_flag <= 1'b0;
         operating_error_flag_a <= 1'b0;
         operating_error_flag_b <= 1'b0;
         gray_err <= 1'b0;
      end
      else
      begin
         if (do_wr && aw_q == `TGL_A_FLAGS)
         begin
            borrow_flag <= borrow_flag & ~w_q[`TGL_F_BORROW];
            zero_flag <= zero_flag & ~w_q[`TGL_F_ZERO];
            operating_error_flag_a <= operating_error_flag_a & ~w_q[`TGL_F_ERR_A];
            operating_error_flag_b <= operating_error_flag_b & ~w_q[`TGL_F_ERR_B];
            gray_err <= gray_err & ~w_q[`TGL_F_GRAY];
         end
         if (do_exec && exec_op == `TGL_OP_TSUB && t_ok)
         begin
            borrow_flag <= h_raw[16]; // [RL3]
            zero_flag <= h_fix == 16'h0 && m_fix == 16'h0 && s_fix == 16'h0; // [RL4]
         end
         if (do_exec && exec_op == `TGL_OP_TSUB && !t_ok)
         begin
            operating_error_flag_a <= 1'b1; // [RL2]
            operating_error_flag_b <= 1'b1;
         end
         if (do_exec && (exec_op == `TGL_OP_B2G || exec_op == `TGL_OP_G2B) && !g_ok)
         begin
            gray_err <= 1'b1; // [RL11]
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         error_code_reg <= 16'h0;
      end
      else if (do_exec && exec_op == `TGL_OP_TSUB && !t_ok)
      begin
         error_code_reg <= `TGL_ERR_TIME; // [RL2]
      end
   end

   // Combining form follows the series behaviour, not a parallel branch
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         contact_out <= 1'b0;
      end
      else if (do_exec)
      begin
         case (form_of(exec_op))
            TGL_FORM_LOAD: contact_out <= hit; // [RL14]
            TGL_FORM_SERIES: contact_out <= contact_out & hit; // [RL15]
            TGL_FORM_COMBINE: contact_out <= contact_out & hit; // [RL16]
            default: contact_out <= contact_out;
         endcase
      end
   end

   // Calendar fields keep their last legal value; timekeeping lives outside
   for (genvar k = 0; k < 7; k++)
   begin : g_cal
      always_ff @(posedge ref_clk)
      begin
         if (!rst_n)
         begin
            cal[k] <= (k >= 1 && k <= 3) ? `TGL_FIELD_MIN : 16'h0; // [RL19]
         end
         else if (cal_ok(k, cal_in[k]))
         begin
            cal[k] <= cal_in[k]; // [RL5] [RL7] [RL8]
         end
      end
   end

   // Read path
   always_comb
   begin
      next_rdata = 32'h0;
      next_rresp = `TGL_RESP_OKAY;
      if (s_axi_araddr == `TGL_A_CTRL)
      begin
         next_rdata = {23'h0, wide, op};
      end
      else if (s_axi_araddr == `TGL_A_OPA)
      begin
         next_rdata = opa;
      end
      else if (s_axi_araddr == `TGL_A_OPB)
      begin
         next_rdata = opb;
      end
      else if (s_axi_araddr >= `TGL_A_TIME && s_axi_araddr <= `TGL_A_TIME_END && s_axi_araddr[1:0] == 2'h0)
      begin
         next_rdata = {16'h0, tm[idx(s_axi_araddr, `TGL_A_TIME)]};
      end
      else if (s_axi_araddr >= `TGL_A_RES && s_axi_araddr <= `TGL_A_RES_END && s_axi_araddr[1:0] == 2'h0)
      begin
         next_rdata = {16'h0, res[idx(s_axi_araddr, `TGL_A_RES)]};
      end
      else if (s_axi_araddr == `TGL_A_FLAGS)
      begin
         next_rdata = {26'h0, contact_out, gray_err, operating_error_flag_b, operating_error_flag_a,
            zero_flag, borrow_flag};
      end
      else if (s_axi_araddr == `TGL_A_ERRC)
      begin
         next_rdata = {16'h0, error_code_reg};
      end
      else if (s_axi_araddr >= `TGL_A_CAL && s_axi_araddr <= `TGL_A_CAL_END && s_axi_araddr[1:0] == 2'h0)
      begin
         next_rdata = {16'h0, cal[idx(s_axi_araddr, `TGL_A_CAL)]};
      end
      else
      begin
         next_rresp = `TGL_RESP_SLVERR;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `TGL_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   logic [17:0] t1_sec, t2_sec, r_sec;
   assign t1_sec = 18'(tm[0]) * `TGL_SEC_HOUR + 18'(tm[1]) * `TGL_SEC_MIN + 18'(tm[2]);
   assign t2_sec = 18'(tm[3]) * `TGL_SEC_HOUR + 18'(tm[4]) * `TGL_SEC_MIN + 18'(tm[5]);
   assign r_sec = 18'(res[0]) * `TGL_SEC_HOUR + 18'(res[1]) * `TGL_SEC_MIN + 18'(res[2]);

   tsub_result_a: assert property (do_exec && exec_op == `TGL_OP_TSUB && t_ok |=> // [RL1]
      r_sec + $past(t2_sec) == $past(t1_sec) || r_sec + $past(t2_sec) == $past(t1_sec) + `TGL_SEC_DAY)
      else $error("time difference wrong");
   time_error_a: assert property (do_exec && exec_op == `TGL_OP_TSUB && !t_ok |=> // [RL2]
      operating_error_flag_a && operating_error_flag_b && error_code_reg == `TGL_ERR_TIME && $stable(res[0]))
      else $error("bad time operand not flagged");
   borrow_wrap_a: assert property (do_exec && exec_op == `TGL_OP_TSUB && t_ok |=> // [RL3]
      borrow_flag == ($past(t1_sec) < $past(t2_sec)) && res[0] <= `TGL_HOUR_MAX)
      else $error("borrow flag wrong");
   zero_flag_a: assert property (do_exec && exec_op == `TGL_OP_TSUB && t_ok |=> // [RL4]
      zero_flag == (r_sec == 18'h0))
      else $error("zero flag wrong");
   cal_copy_a: assert property (do_exec && exec_op == `TGL_OP_CALRD |=> // [RL6]
      res[0] == $past(cal[0]) && res[1] == $past(cal[1]) && res[6] == $past(cal[6]))
      else $error("calendar copy wrong");
   cal_range_a: assert property (cal[2] >= `TGL_FIELD_MIN && cal[2] <= `TGL_MONTH_MAX // [RL5]
      && cal[4] <= `TGL_HOUR_MAX && cal[6] <= `TGL_MIN_MAX) else $error("calendar field out of range");
   year_week_a: assert property (cal[0] <= `TGL_YEAR_MAX && cal[1] >= `TGL_FIELD_MIN // [RL7]
      && cal[1] <= `TGL_WDAY_MAX) else $error("year or weekday out of range");
   gray_enc_a: assert property (do_exec && exec_op == `TGL_OP_B2G && !exec_wide && g_ok |=> // [RL9]
      gray_to_binary({16'h0, res[0]}) == {16'h0, $past(opa[15:0])}) else $error("gray encode wrong");
   gray_dec_a: assert property (do_exec && exec_op == `TGL_OP_G2B && exec_wide && g_ok |=> // [RL10]
      ({res[1], res[0]} ^ ({res[1], res[0]} >> 1)) == $past(opa)) else $error("gray decode wrong");
   gray_range_a: assert property (do_exec && exec_op == `TGL_OP_G2B && !g_ok |=> // [RL11]
      gray_err && $stable(res[0]) && $stable(res[1])) else $error("gray range not enforced");
   load_and_a: assert property (do_exec && exec_op == `TGL_OP_LD_AND && !exec_wide |=> // [RL14]
      contact_out == |($past(opa[15:0]) & $past(opb[15:0]))) else $error("load contact wrong");
   series_line_a: assert property (do_exec && form_of(exec_op) != TGL_FORM_NONE // [RL15]
      && form_of(exec_op) != TGL_FORM_LOAD && !contact_out |=> !contact_out) else $error("series contact wrong");
   wide_xor_a: assert property (do_exec && exec_op == `TGL_OP_LD_XOR && exec_wide |=> // [RL17]
      contact_out == |($past(opa) ^ $past(opb))) else $error("wide contact wrong");

   borrow_seen_c: cover property (do_exec && exec_op == `TGL_OP_TSUB ##1 borrow_flag);
   cal_read_c: cover property (do_exec && exec_op == `TGL_OP_CALRD);
   gray_err_c: cover property (do_exec && exec_op == `TGL_OP_B2G ##1 gray_err);
   series_on_c: cover property (do_exec && exec_op == `TGL_OP_SE_OR ##1 contact_out);

endmodule

// File: plc_time_gray_logic_ops_tb_top.sv
/*
 Self-checking bench for the time, Gray and logic-contact datapath, acting as AXI4-Lite master.
 Assumes tgl_exec_top carries its own assertions and answers every bus request within 200 cycles.
*/
`timescale 1ns/1ps
`include "tgl_consts.svh"
module plc_time_gray_logic_ops_tb_top;
   import tgl_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] awaddr = 7'h00;
   logic [6:0] araddr = 7'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic arvalid = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, contact_out, err_a, err_b;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic [15:0] cal_in [0:6] = '{default: 16'h0000};
   logic [15:0] er [0:6] = '{default: 16'h0000};
   logic [31:0] seed = 32'h6573;
   logic line = 1'b0;
   int failures = 0;
   int n_compared = 0;

   // Ready lines held high: the bench always accepts answers at once
   tgl_exec_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'b1), .cal_in(cal_in), .contact_out(contact_out),
      .operating_error_flag_a(err_a), .operating_error_flag_b(err_b));

   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] gray_exp(input logic back, input logic [31:0] x);
      logic [31:0] y;
      y = back ? x : x ^ (x >> 1);
      if (back)
         for (int i = 30; i >= 0; i--)
            y[i] = y[i + 1] ^ x[i];
      return y;
   endfunction

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      rsp = bresp;
      if (n >= 200)
      begin
         failures++;
         close_out();
      end
   endtask

   task automatic rdr(input logic [6:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      rd = rdata;
      rsp = rresp;
      if (n >= 200)
      begin
         failures++;
         close_out();
      end
   endtask

   task automatic rchk(input string nm, input logic [6:0] a, input logic [31:0] exp);
      rdr(a);
      chk("rresp", 32'(`TGL_RESP_OKAY), 32'(rsp));
      chk(nm, exp, rd);
   endtask

   task automatic op(input logic [7:0] c, input logic w);
      wr(`TGL_A_CTRL, {23'h0, w, c});
   endtask

   task automatic tsub(input int t [6]);
      int d;
      logic bad;
      bad = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         bad |= t[i] > ((i % 3 == 0) ? 23 : 59);
         wr(7'(`TGL_A_TIME + 4 * i), 32'(t[i]));
      end
      wr(`TGL_A_FLAGS, 32'h1f);
      op(`TGL_OP_TSUB, 1'b0);
      d = t[0] * 3600 + t[1] * 60 + t[2] - t[3] * 3600 - t[4] * 60 - t[5];
      if (bad)
      begin
         rchk("flags", `TGL_A_FLAGS, 32'({line, 5'h0c}));
         rchk("errcode", `TGL_A_ERRC, 32'h0e1a);
         chk("errpins", 32'h3, {30'h0, err_a, err_b});
      end
      else
      begin
         rchk("flags", `TGL_A_FLAGS, 32'({line, 3'h0, d == 0, d < 0}));
         if (d < 0)
            d += 86400;
         er[0] = 16'(d / 3600);
         er[1] = 16'(d / 60 % 60);
         er[2] = 16'(d % 60);
      end
      for (int i = 0; i < 3; i++)
         rchk("tres", 7'(`TGL_A_RES + 4 * i), 32'(er[i]));
   endtask

   task automatic gray(input logic back, input logic w);
      logic [31:0] x, y;
      logic e;
      x = xs();
      if (!w)
         x = x & 32'h0000ffff;
      wr(`TGL_A_OPA, x);
      wr(`TGL_A_FLAGS, 32'h1f);
      op(back ? `TGL_OP_G2B : `TGL_OP_B2G, w);
      y = gray_exp(back, x);
      e = w ? x[31] : x[15];
      rchk("flags", `TGL_A_FLAGS, 32'({line, e, 4'h0}));
      if (!e)
         er[0] = y[15:0];
      if (!e && w)
         er[1] = y[31:16];
      rchk("gres0", `TGL_A_RES, 32'(er[0]));
      if (w)
         rchk("gres1", 7'(`TGL_A_RES + 4), 32'(er[1]));
   endtask

   task automatic contact(input int code, input logic w);
      logic [31:0] a, b, c;
      int k, m;
      a = xs();
      b = xs();
      m = xs() % 4;
      k = (code - 215) % 3;
      if (m == 2)
         a = 32'h0;
      if (m == 1)
         b = ~a;
      if (m >= 2)
         b = a;
      wr(`TGL_A_OPA, a);
      wr(`TGL_A_OPB, b);
      op(8'(code), w);
      c = k == 0 ? a & b : k == 1 ? a | b : a ^ b;
      if (!w)
         c = c & 32'h0000ffff;
      // Combining forms act in series with the line
      line = (code < 218 ? 1'b1 : line) & (c != 32'h0);
      chk("contact", 32'(line), 32'(contact_out));
   endtask

   task automatic cal();
      int lo [7] = '{0, 1, 1, 1, 0, 0, 0};
      int sp [7] = '{100, 7, 12, 31, 24, 60, 60};
      int f;
      for (int i = 0; i < 7; i++)
      begin
         er[i] = 16'(lo[i] + xs() % sp[i]);
         cal_in[i] <= er[i];
      end
      repeat (3) @(posedge ref_clk);
      f = xs() % 7;
      // One field just past its range must be ignored
      cal_in[f] <= 16'(lo[f] + sp[f]);
      repeat (3) @(posedge ref_clk);
      op(`TGL_OP_CALRD, 1'b0);
      for (int i = 0; i < 7; i++)
      begin
         rchk("calreg", 7'(`TGL_A_CAL + 4 * i), 32'(er[i]));
         rchk("calres", 7'(`TGL_A_RES + 4 * i), 32'(er[i]));
      end
   endtask

   initial
   begin
      int tc [5][6] = '{'{5, 6, 7, 5, 6, 7}, '{0, 0, 0, 0, 0, 1}, '{23, 59, 59, 0, 0, 0},
         '{24, 0, 0, 1, 0, 0}, '{1, 2, 3, 4, 60, 0}};
      int t [6];
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk("weekday", 7'(`TGL_A_CAL + 4), 32'h1);
      rchk("flags", `TGL_A_FLAGS, 32'h0);
      rdr(7'h64);
      chk("unmapped", {30'h0, `TGL_RESP_SLVERR}, {30'h0, rsp});
      chk("unmapdata", 32'h0, rd);
      wr(7'h06, 32'h0);
      chk("misaligned", {30'h0, `TGL_RESP_SLVERR}, {30'h0, rsp});
      // Byte strobes: only lanes 0 and 2 may change
      wr(`TGL_A_OPA, 32'h11223344);
      wstrb <= 4'h5;
      wr(`TGL_A_OPA, 32'haabbccdd);
      wstrb <= 4'hf;
      rchk("strobe", `TGL_A_OPA, 32'h11bb33dd);
      for (int i = 0; i < 5; i++)
         tsub(tc[i]);
      repeat (20)
      begin
         for (int j = 0; j < 6; j++)
            t[j] = xs() % ((j % 3 == 0) ? 24 : 60);
         tsub(t);
      end
      repeat (3) cal();
      for (int i = 0; i < 16; i++)
         gray(i[0], i[1]);
      for (int r = 0; r < 4; r++)
         for (int code = 215; code <= 223; code++)
            for (int w = 0; w < 2; w++)
               contact(code, w[0]);
      close_out();
   end
endmodule
